/* File: verilog/tbs_pkg.sv */
// constants for the trace buffer store and readout block
package tbs_pkg;
    // register byte addresses
    localparam logic [7:0] TBS_TRACE_CONTROL_REG = 8'h00;
    localparam logic [7:0] TBS_ARM_CTRL_REG = 8'h01;
    localparam logic [7:0] TBS_TRACE_DATA_PORT_HIGH = 8'h02;
    localparam logic [7:0] TBS_TRACE_DATA_PORT_LOW = 8'h03;
    localparam logic [7:0] TBS_VALID_LINE_COUNTER = 8'h04;
    localparam logic [7:0] TBS_STATUS_REG = 8'h05;
    // trace_control_reg fields
    localparam int TBS_SRC_EN_BIT = 0;
    localparam int TBS_MODE_LSB = 2;
    localparam int TBS_MODE_MSB = 3;
    // arm control fields
    localparam int TBS_ARM_BIT = 0;
    localparam int TBS_BEGIN_BIT = 1;
    // status fields
    localparam int TBS_ST_ARMED_BIT = 0;
    localparam int TBS_ST_LOCKED_BIT = 1;
    localparam int TBS_ST_OVF_BIT = 2;
    localparam int TBS_ST_TRIG_BIT = 3;
    // reset values
    localparam logic [7:0] TBS_TRACE_CONTROL_RST = 8'h00;
    localparam logic TBS_BEGIN_RST = 1'b0;
    // trace_mode_select encodings
    localparam logic [1:0] TBS_MODE_NORMAL = 2'h0;
    localparam logic [1:0] TBS_MODE_LOOP = 2'h1;
    localparam logic [1:0] TBS_MODE_DETAIL = 2'h2;
    localparam logic [1:0] TBS_MODE_PURE_PC = 2'h3;
    // buffer geometry
    localparam int TBS_LINE_W = 20;
    localparam int TBS_PTR_W = 6;
    localparam int TBS_CNT_W = 7;
    localparam logic [6:0] TBS_LINES = 7'h40;
    localparam logic [6:0] TBS_BEGIN_LINES = 7'h40;
endpackage : tbs_pkg

/* File: verilog/tbs_trace_buffer.sv */
// trace line formatting, storage, locking and word readout
`timescale 1ns/100ps
module tbs_trace_buffer
    import tbs_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic word_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // system state
    input wire logic secure_i,
    input wire logic trigger_i,
    // change of flow capture
    input wire logic cof_valid_i,
    input wire logic [17:0] cof_pc_i,
    input wire logic cof_dest_i,
    input wire logic cof_vector_i,
    // executed opcode capture
    input wire logic opcode_valid_i,
    input wire logic [17:0] opcode_pc_i,
    // bus access capture
    input wire logic acc_valid_i,
    input wire logic [17:0] acc_addr_i,
    input wire logic acc_byte_i,
    input wire logic acc_read_i,
    input wire logic [15:0] acc_data_i,
    // state towards sequencer and breakpoint logic
    output logic armed_o,
    output logic locked_o
);
    // lines, write pointer, counts and overflow have no reset: a session survives the system reset
    logic [TBS_LINE_W-1:0] mem [0:(1<<TBS_PTR_W)-1];
    logic [7:0] trace_control_reg;
    logic begin_align;
    logic armed;
    logic locked;
    logic triggered;
    logic overflow;
    logic [TBS_PTR_W-1:0] wr_ptr;
    logic [TBS_CNT_W-1:0] valid_line_counter;
    logic [TBS_CNT_W-1:0] session_lines;
    logic [TBS_PTR_W-1:0] rd_ptr;
    logic rd_half;
    logic [17:0] last_addr;
    logic last_valid;
    logic [15:0] rdata;

    logic [1:0] trace_mode_select;
    logic trace_source_enable;
    logic aligned_word;
    logic wr_ctrl;
    logic wr_arm;
    logic wr_port_high;
    logic rd_port;
    logic read_ok;
    logic storing;
    logic [TBS_LINE_W-1:0] next_line0;
    logic [TBS_LINE_W-1:0] next_line1;
    logic [1:0] next_n;
    logic [17:0] next_addr;
    logic [TBS_CNT_W-1:0] next_count;
    logic [TBS_PTR_W-1:0] oldest_ptr;
    logic [TBS_LINE_W-1:0] rd_line;
    logic arm_set;
    logic store_en;
    logic [TBS_CNT_W-1:0] next_session;
    logic wraps;
    logic bad_access;

    // control register fields
    assign trace_mode_select =
        trace_control_reg[TBS_MODE_MSB:TBS_MODE_LSB];
    assign trace_source_enable = trace_control_reg[TBS_SRC_EN_BIT];
    // the trace port takes aligned word accesses only
    assign aligned_word = word_i && !addr_i[0];
    assign wr_ctrl = wr_i && addr_i == TBS_TRACE_CONTROL_REG;
    assign wr_arm = wr_i && addr_i == TBS_ARM_CTRL_REG;
    assign wr_port_high = wr_i && aligned_word
        && addr_i == TBS_TRACE_DATA_PORT_HIGH;
    assign rd_port = rd_i && aligned_word
        && addr_i == TBS_TRACE_DATA_PORT_HIGH;
    // readout is possible only when every gate is open
    assign read_ok = !armed && !locked && trace_source_enable
        && !secure_i;
    // end alignment stores until the trigger, begin alignment after it
    assign storing = armed && trace_source_enable
        && (begin_align ? triggered : 1'b1);
    // oldest line: line 0 unless the session wrapped
    assign oldest_ptr = overflow ? wr_ptr : '0;
    assign rd_line = mem[rd_ptr];
    // arming starts a fresh session and clears its history
    assign arm_set = wr_arm && wdata_i[TBS_ARM_BIT];
    assign store_en = storing && next_n != 2'd0;
    assign next_session = session_lines + TBS_CNT_W'(next_n);
    // more lines than the buffer holds: the oldest were overwritten
    assign wraps = valid_line_counter + TBS_CNT_W'(next_n) > TBS_LINES;
    // byte or odd-address access to the word-only trace port
    assign bad_access = !aligned_word && addr_i != TBS_TRACE_CONTROL_REG
        && addr_i != TBS_ARM_CTRL_REG && addr_i != TBS_STATUS_REG
        && addr_i != TBS_VALID_LINE_COUNTER;

    // format the lines that a capture event produces
    always_comb begin
        next_line0 = '0;
        next_line1 = '0;
        next_n = 2'd0;
        next_addr = last_addr;
        case (trace_mode_select)
            TBS_MODE_NORMAL, TBS_MODE_LOOP: begin
                if (cof_valid_i) begin
                    // vector entries are always destinations
                    next_line0 = {cof_dest_i | cof_vector_i,
                        cof_vector_i,
                        cof_pc_i[17:16],
                        cof_pc_i[15:0]};
                    next_addr = cof_pc_i;
                    next_n = 2'd1;
                    // loop mode drops a repeated source entry
                    if (trace_mode_select == TBS_MODE_LOOP && !cof_dest_i
                        && !cof_vector_i && last_valid
                        && cof_pc_i == last_addr) begin
                        next_n = 2'd0;
                    end
                end
            end
            TBS_MODE_PURE_PC: begin
                if (opcode_valid_i) begin
                    next_line0 = {2'b00, opcode_pc_i[17:16],
                        opcode_pc_i[15:0]};
                    next_n = 2'd1;
                end
            end
            TBS_MODE_DETAIL: begin
                if (acc_valid_i) begin
                    next_line0 = {acc_byte_i,
                        acc_read_i,
                        acc_addr_i[17:16],
                        acc_addr_i[15:0]};
                    if (acc_byte_i) begin
                        next_line1 = {4'h0, 8'h00, acc_data_i[7:0]};
                    end else begin
                        // word data keeps its high byte in the upper lane
                        next_line1 = {4'h0, acc_data_i[15:8],
                            acc_data_i[7:0]};
                    end
                    next_n = 2'd2;
                end
            end
            default: begin
                next_n = 2'd0;
            end
        endcase
    end

    // lines counted after this cycle, saturating at buffer depth
    always_comb begin
        next_count = valid_line_counter + TBS_CNT_W'(next_n);
        if (next_count > TBS_LINES) begin
            next_count = TBS_LINES;
        end
    end

    // control register, kept across sessions
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            trace_control_reg <= TBS_TRACE_CONTROL_RST;
        end else if (wr_ctrl) begin
            trace_control_reg <= wdata_i[7:0];
        end
    end

    // arm state: end alignment disarms on the trigger, begin alignment
    // once a full buffer of lines has been stored after it
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            armed <= 1'b0;
        end else if (wr_arm) begin
            armed <= wdata_i[TBS_ARM_BIT];
        end else if (armed) begin
            if (!begin_align && trigger_i) begin
                armed <= 1'b0;
            end
            if (begin_align && storing
                && next_session >= TBS_BEGIN_LINES) begin
                armed <= 1'b0;
            end
        end
    end

    // trigger alignment, chosen with each arm control write
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            begin_align <= TBS_BEGIN_RST;
        end else if (wr_arm) begin
            begin_align <= wdata_i[TBS_BEGIN_BIT];
        end
    end

    // trigger seen in this session; a trigger beats a clearing write
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            triggered <= 1'b0;
        end else if (armed && trigger_i) begin
            triggered <= 1'b1;
        end else if (wr_arm) begin
            triggered <= 1'b0;
        end
    end

    // lock: set by arming, cleared only by the unlock write
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            locked <= 1'b1;
        end else if (wr_arm && wdata_i[TBS_ARM_BIT]) begin
            locked <= 1'b1;
        end else if (wr_port_high && !armed) begin
            locked <= 1'b0;
        end
    end

    // line storage; a detail entry fills two lines in one cycle
    always_ff @(posedge mclk_i) begin
        if (store_en) begin
            mem[wr_ptr] <= next_line0;
            if (next_n == 2'd2) begin
                mem[wr_ptr + TBS_PTR_W'(1)] <= next_line1;
            end
        end
    end

    // write pointer, restarted by arming, wraps at buffer depth
    always_ff @(posedge mclk_i) begin
        if (arm_set) begin
            wr_ptr <= '0;
        end else if (store_en) begin
            wr_ptr <= wr_ptr + TBS_PTR_W'(next_n);
        end
    end

    // valid lines; only arming clears them, not the system reset
    always_ff @(posedge mclk_i) begin
        if (arm_set) begin
            valid_line_counter <= '0;
        end else if (store_en) begin
            valid_line_counter <= next_count;
        end
    end

    // lines stored since arming, for the begin alignment stop
    always_ff @(posedge mclk_i) begin
        if (arm_set) begin
            session_lines <= '0;
        end else if (store_en) begin
            session_lines <= next_session;
        end
    end

    // overflow moves the oldest line away from line 0
    always_ff @(posedge mclk_i) begin
        if (arm_set) begin
            overflow <= 1'b0;
        end else if (store_en && wraps) begin
            overflow <= 1'b1;
        end
    end

    // background copy of the last stored change of flow address for loop filtering
    always_ff @(posedge mclk_i) begin
        if (arm_set) begin
            last_valid <= 1'b0;
        end else if (store_en) begin
            last_addr <= next_addr;
            last_valid <= 1'b1;
        end
    end

    // read pointer and half-line select
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rd_ptr <= '0;
            rd_half <= 1'b0;
        end else if (wr_port_high) begin
            // any aligned word write rewinds, armed or not
            rd_ptr <= oldest_ptr;
            rd_half <= 1'b0;
        end else if (rd_port && read_ok) begin
            // low word first, then field2; pointer moves after both
            rd_half <= !rd_half;
            if (rd_half) begin
                rd_ptr <= rd_ptr + TBS_PTR_W'(1);
            end
        end
    end

    // read data, valid in the cycle after the strobe
    always_comb begin
        rdata = 16'h0000;
        if (bad_access) begin
            rdata = 16'h0000;
        end else begin
            case (addr_i)
                TBS_TRACE_CONTROL_REG: begin
                    rdata = {8'h00, trace_control_reg};
                end
                TBS_ARM_CTRL_REG: begin
                    rdata = {14'h0000, begin_align, armed};
                end
                TBS_TRACE_DATA_PORT_HIGH: begin
                    if (read_ok) begin
                        rdata = rd_half ? {12'h000, rd_line[19:16]}
                            : rd_line[15:0];
                    end else begin
                        rdata = 16'h0000;
                    end
                end
                TBS_VALID_LINE_COUNTER: begin
                    rdata = {9'h000, valid_line_counter};
                end
                TBS_STATUS_REG: begin
                    rdata = {12'h000, triggered, overflow, locked, armed};
                end
                default: begin
                    rdata = 16'h0000;
                end
            endcase
        end
    end

    // read data stands one cycle, zero otherwise
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            rdata_o <= rdata;
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    assign armed_o = armed;
    assign locked_o = locked;

endmodule : tbs_trace_buffer

/* File: dv/tbs_chk_sva.sv */
// register-port assertions for the trace buffer block
`timescale 1ns/100ps
module tbs_chk
    import tbs_pkg::*;
(
    input logic mclk_i,
    input logic rst_i,
    input logic [7:0] addr_i,
    input logic [15:0] wdata_i,
    input logic word_i,
    input logic wr_i,
    input logic rd_i,
    input logic [15:0] rdata_o,
    input logic secure_i,
    input logic armed_o,
    input logic locked_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic src_en;
    logic hi_word;
    wire port_wr = wr_i && addr_i == TBS_TRACE_DATA_PORT_HIGH;
    wire port_rd = rd_i && addr_i == TBS_TRACE_DATA_PORT_HIGH;
    wire unlock_wr = port_wr && word_i && !armed_o;
    wire ok_rd = port_rd && word_i && !armed_o && !locked_o && !secure_i
        && src_en;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            src_en <= 1'b0;
        end else if (wr_i && addr_i == TBS_TRACE_CONTROL_REG) begin
            src_en <= wdata_i[TBS_SRC_EN_BIT];
        end
    end
    // tracks which half of a line the next good read returns
    always_ff @(posedge mclk_i) begin
        if (rst_i || (port_wr && word_i)) begin
            hi_word <= 1'b0;
        end else if (ok_rd) begin
            hi_word <= !hi_word;
        end
    end
    chk_byte_read_zero: assert property (
        port_rd && !word_i |=> rdata_o == 16'h0000) else $error("byte read");
    chk_armed_read_zero: assert property (
        port_rd && armed_o |=> rdata_o == 16'h0000) else $error("armed read");
    chk_locked_read_zero: assert property (
        port_rd && locked_o |=> rdata_o == 16'h0000) else $error("lock read");
    chk_secure_read_zero: assert property (
        port_rd && secure_i |=> rdata_o == 16'h0000) else $error("secure");
    chk_src_off_zero: assert property (
        port_rd && !src_en |=> rdata_o == 16'h0000) else $error("src off");
    chk_arm_locks: assert property (
        wr_i && addr_i == TBS_ARM_CTRL_REG && wdata_i[TBS_ARM_BIT]
        |=> armed_o && locked_o) else $error("arm did not lock");
    chk_unlock_cause: assert property (
        $fell(locked_o) |-> $past(unlock_wr)) else $error("stray unlock");
    chk_field2_upper: assert property (
        ok_rd && hi_word |=> rdata_o[15:4] == 12'h000) else $error("upper");
    cov_unlock: cover property ($fell(locked_o));
    cov_disarm: cover property ($fell(armed_o));
    cov_hi_read: cover property (ok_rd && hi_word);
endmodule : tbs_chk

bind tbs_trace_buffer tbs_chk u_chk (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .word_i(word_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .secure_i(secure_i),
    .armed_o(armed_o),
    .locked_o(locked_o)
);

/* File: dv/tbs_cpu_model.sv */
// cpu side model that feeds capture pulses to the trace buffer
`timescale 1ns/100ps
module tbs_cpu_model (
    input logic mclk_i,
    output logic cof_valid_o,
    output logic [17:0] cof_pc_o,
    output logic cof_dest_o,
    output logic cof_vector_o,
    output logic opcode_valid_o,
    output logic [17:0] opcode_pc_o,
    output logic acc_valid_o,
    output logic [17:0] acc_addr_o,
    output logic acc_byte_o,
    output logic acc_read_o,
    output logic [15:0] acc_data_o
);
    initial begin
        {cof_valid_o, opcode_valid_o, acc_valid_o} = 3'h0;
        {cof_pc_o, cof_dest_o, cof_vector_o} = 20'h0_0000;
        opcode_pc_o = 18'h0_0000;
        {acc_addr_o, acc_byte_o, acc_read_o, acc_data_o} = 36'h0_0000_0000;
    end
    // fields are scrambled once the pulse is over
    task automatic cof(input logic [17:0] pc, input logic d, input logic v);
        cof_valid_o <= 1'b1;
        {cof_pc_o, cof_dest_o, cof_vector_o} <= {pc, d, v};
        @(posedge mclk_i);
        cof_valid_o <= 1'b0;
        {cof_pc_o, cof_dest_o, cof_vector_o} <= ~{pc, d, v};
        @(posedge mclk_i);
    endtask : cof
    task automatic op(input logic [17:0] pc);
        opcode_valid_o <= 1'b1;
        opcode_pc_o <= pc;
        @(posedge mclk_i);
        opcode_valid_o <= 1'b0;
        opcode_pc_o <= ~pc;
        @(posedge mclk_i);
    endtask : op
    task automatic acc(input logic [17:0] a, input logic b, input logic r,
        input logic [15:0] d);
        acc_valid_o <= 1'b1;
        {acc_addr_o, acc_byte_o, acc_read_o, acc_data_o} <= {a, b, r, d};
        @(posedge mclk_i);
        acc_valid_o <= 1'b0;
        {acc_addr_o, acc_byte_o, acc_read_o, acc_data_o} <= ~{a, b, r, d};
        @(posedge mclk_i);
    endtask : acc
endmodule : tbs_cpu_model

/* File: dv/tb_top.sv */
// self-checking testbench for the trace buffer block
`timescale 1ns/100ps
module tb_top
    import tbs_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic word_i = 1'b1;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic secure_i = 1'b0;
    logic trigger_i = 1'b0;
    logic [15:0] rdata_o, acc_data_i;
    logic armed_o, locked_o, cof_valid_i, cof_dest_i, cof_vector_i;
    logic opcode_valid_i, acc_valid_i, acc_byte_i, acc_read_i;
    logic [17:0] cof_pc_i, opcode_pc_i, acc_addr_i;
    logic [19:0] exp_q[$];
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    tbs_trace_buffer u_dut (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .word_i(word_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .secure_i(secure_i),
        .trigger_i(trigger_i),
        .cof_valid_i(cof_valid_i),
        .cof_pc_i(cof_pc_i),
        .cof_dest_i(cof_dest_i),
        .cof_vector_i(cof_vector_i),
        .opcode_valid_i(opcode_valid_i),
        .opcode_pc_i(opcode_pc_i),
        .acc_valid_i(acc_valid_i),
        .acc_addr_i(acc_addr_i),
        .acc_byte_i(acc_byte_i),
        .acc_read_i(acc_read_i),
        .acc_data_i(acc_data_i),
        .armed_o(armed_o),
        .locked_o(locked_o)
    );
    tbs_cpu_model u_cpu (.mclk_i(mclk_i), .cof_valid_o(cof_valid_i),
        .cof_pc_o(cof_pc_i), .cof_dest_o(cof_dest_i),
        .cof_vector_o(cof_vector_i), .opcode_valid_o(opcode_valid_i),
        .opcode_pc_o(opcode_pc_i), .acc_valid_o(acc_valid_i),
        .acc_addr_o(acc_addr_i), .acc_byte_o(acc_byte_i),
        .acc_read_o(acc_read_i), .acc_data_o(acc_data_i));
    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic w,
        output logic [15:0] d);
        addr_i <= a;
        word_i <= w;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        word_i <= 1'b1;
        @(negedge mclk_i);
        d = rdata_o;
        @(posedge mclk_i);
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic w,
        input logic [15:0] e);
        logic [15:0] d;
        rd(a, w, d);
        chk({4'h0, d}, {4'h0, e});
    endtask : rdc
    // two word reads per line, field2 compared under a mask
    task automatic read_lines(input int n, input logic [3:0] m);
        logic [15:0] lo, hi;
        logic [19:0] e;
        repeat (n) begin
            e = exp_q.pop_front();
            rd(TBS_TRACE_DATA_PORT_HIGH, 1'b1, lo);
            rd(TBS_TRACE_DATA_PORT_HIGH, 1'b1, hi);
            chk({hi[3:0] & m, lo}, {e[19:16] & m, e[15:0]});
        end
    endtask : read_lines
    task automatic start(input logic [7:0] ctl, input logic [7:0] arm);
        wr(TBS_TRACE_CONTROL_REG, {8'h00, ctl});
        wr(TBS_ARM_CTRL_REG, {8'h00, arm});
        chk({18'h0_0000, armed_o, locked_o}, 20'h0_0003);
    endtask : start
    task automatic trig();
        trigger_i <= 1'b1;
        @(posedge mclk_i);
        trigger_i <= 1'b0;
        @(posedge mclk_i);
    endtask : trig
    task automatic stop(input logic [6:0] n);
        logic [15:0] d;
        chk({19'h0_0000, armed_o}, 20'h0_0000);
        rdc(TBS_TRACE_DATA_PORT_HIGH, 1'b1, 16'h0000);
        wr(TBS_TRACE_DATA_PORT_HIGH, 16'h0000);
        rd(TBS_VALID_LINE_COUNTER, 1'b1, d);
        chk({13'h0000, d[6:0]}, {13'h0000, n});
    endtask : stop
    task automatic t_detail();
        start(8'h09, 8'h01);
        u_cpu.acc(18'h2_1234, 1'b1, 1'b1, 16'h77ab);
        u_cpu.acc(18'h1_5678, 1'b0, 1'b0, 16'hcdef);
        rdc(TBS_TRACE_DATA_PORT_HIGH, 1'b1, 16'h0000);
        trig();
        stop(7'h04);
        rdc(TBS_TRACE_DATA_PORT_HIGH, 1'b0, 16'h0000);
        rdc(TBS_TRACE_DATA_PORT_LOW, 1'b1, 16'h0000);
        exp_q = '{20'he_1234, 20'h0_00ab, 20'h1_5678, 20'h0_cdef};
        read_lines(4, 4'hf);
        wr(TBS_TRACE_DATA_PORT_HIGH, 16'h0000);
        exp_q = '{20'he_1234};
        read_lines(1, 4'hf);
        rst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        wr(TBS_TRACE_CONTROL_REG, 16'h0009);
        stop(7'h04);
        exp_q = '{20'he_1234, 20'h0_00ab};
        read_lines(2, 4'hf);
        secure_i <= 1'b1;
        wr(TBS_TRACE_DATA_PORT_HIGH, 16'h0000);
        rdc(TBS_TRACE_DATA_PORT_HIGH, 1'b1, 16'h0000);
        secure_i <= 1'b0;
        wr(TBS_TRACE_CONTROL_REG, 16'h0008);
        rdc(TBS_TRACE_DATA_PORT_HIGH, 1'b1, 16'h0000);
    endtask : t_detail
    task automatic t_flow(input logic [7:0] ctl);
        start(ctl, 8'h01);
        u_cpu.cof(18'h3_0100, 1'b0, 1'b0);
        u_cpu.cof(18'h3_0100, 1'b0, 1'b0);
        u_cpu.cof(18'h0_2000, 1'b1, 1'b0);
        u_cpu.cof(18'h0_2000, 1'b1, 1'b0);
        u_cpu.cof(18'h1_fff2, 1'b0, 1'b1);
        trig();
        exp_q = '{20'h3_0100, 20'h3_0100, 20'h8_2000, 20'h8_2000,
            20'hd_fff2};
        if (ctl == 8'h05) begin
            void'(exp_q.pop_front());
            stop(7'h04);
            read_lines(4, 4'hf);
        end else begin
            stop(7'h05);
            read_lines(5, 4'hf);
        end
    endtask : t_flow
    task automatic t_pure();
        start(8'h0d, 8'h01);
        for (int i = 0; i < 70; i++) u_cpu.op(18'h2_0000 + 18'(i));
        trig();
        stop(7'h40);
        exp_q = '{20'h2_0006, 20'h2_0007};
        read_lines(2, 4'h3);
        rdc(TBS_STATUS_REG, 1'b1, 16'h000c);
    endtask : t_pure
    task automatic t_begin();
        start(8'h0d, 8'h03);
        repeat (3) u_cpu.op(18'h1_0000);
        trig();
        for (int i = 0; i < 63; i++) u_cpu.op(18'h1_0010 + 18'(i));
        chk({19'h0_0000, armed_o}, 20'h0_0001);
        u_cpu.op(18'h1_00ff);
        stop(7'h40);
        exp_q = '{20'h1_0010};
        read_lines(1, 4'h3);
        rdc(TBS_STATUS_REG, 1'b1, 16'h0008);
        rdc(TBS_ARM_CTRL_REG, 1'b1, 16'h0002);
        rdc(TBS_TRACE_CONTROL_REG, 1'b1, 16'h000d);
    endtask : t_begin
    initial begin
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_detail();
        t_flow(8'h01);
        t_flow(8'h05);
        t_pure();
        t_begin();
        wrap_up();
    end
endmodule : tb_top
